// [src/fhsm_history.sv]
// five-deep fault history, newest in entry one.
// assumes shift and clear are single-cycle pulses from the monitor top.
`timescale 1ns/1ns
module fhsm_history (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic shiftIn,
    input wire logic clearAll,
    input fhsm_pkg::fhsm_record_type newRecord,
    input wire logic [2:0] readIndex,
    output fhsm_pkg::fhsm_record_type readRecord
);
    fhsm_pkg::fhsm_record_type entry_reg [fhsm_pkg::HIST_DEPTH];

    genvar gi;
    generate
        for (gi = 0; gi < fhsm_pkg::HIST_DEPTH; gi++) begin : g_entry
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    entry_reg[gi] <= fhsm_pkg::EMPTY_RECORD;
                end else if (clearAll) begin
                    entry_reg[gi] <= fhsm_pkg::EMPTY_RECORD;
                end else if (shiftIn) begin
                    if (gi == 0) begin
                        entry_reg[gi] <= newRecord;
                    end else begin
                        // last entry's old content falls off the end
                        entry_reg[gi] <= entry_reg[gi-1];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            readRecord <= fhsm_pkg::EMPTY_RECORD;
        end else if (readIndex < 3'(fhsm_pkg::HIST_DEPTH)) begin
            readRecord <= entry_reg[readIndex];
        end else begin
            readRecord <= fhsm_pkg::EMPTY_RECORD;
        end
    end
endmodule : fhsm_history

// [src/fhsm_monitor.sv]
// top of the status and fault record monitor.
// assumes the drive core gives trip pulses with snapshot values, and the keypad
// reads by parameter code with an item selector; all inputs synchronous to core_clk.
`timescale 1ns/1ns
module fhsm_monitor #(
    parameter bit ADVANCED_IO = 1'b1
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [4:0] terminalLevel,
    input wire logic relayOn,
    input wire logic openCollectorOn,
    input wire logic tripPulse,
    input wire logic [7:0] tripCode,
    input wire logic [15:0] tripFrequency,
    input wire logic [15:0] tripCurrent,
    input fhsm_pkg::fhsm_phase_type tripPhase,
    input wire logic faultResetPulse,
    input wire logic [7:0] regCode,
    input wire logic [1:0] regItem,
    input wire logic regWrite,
    input wire logic [15:0] regWriteData,
    output logic [15:0] regReadData,
    output logic tripActive
);
    fhsm_pkg::fhsm_record_type current_reg;
    fhsm_pkg::fhsm_record_type histRecord;
    logic [4:0] inputState_reg;
    logic [1:0] outputState_reg;
    logic histClear_reg;
    logic [2:0] histIndex;
    logic [15:0] readNext;

    ////////////////////////////////////////////////////////////////////////////
    // live terminal snapshots
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            inputState_reg <= 5'h00;
        end else if (ADVANCED_IO) begin
            inputState_reg <= terminalLevel;
        end else begin
            // terminals four and five do not exist on the standard board
            inputState_reg <= {2'h0, terminalLevel[fhsm_pkg::NUM_STD_INPUTS-1:0]};
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            outputState_reg <= fhsm_pkg::OUT_STATE_RESET;
        end else begin
            outputState_reg <= {openCollectorOn, relayOn};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // active trip record
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            current_reg <= fhsm_pkg::EMPTY_RECORD;
            tripActive <= 1'b0;
        end else if (tripPulse) begin
            // a trip in the reset cycle wins: it starts a fresh record
            tripActive <= 1'b1;
            if (tripActive && !faultResetPulse) begin
                // simultaneous trips merge: codes or'ed, first snapshot kept
                current_reg.faultCode <= current_reg.faultCode | tripCode;
            end else begin
                current_reg <= '{faultCode: tripCode, frequency: tripFrequency,
                    current: tripCurrent, phase: tripPhase};
            end
        end else if (faultResetPulse) begin
            tripActive <= 1'b0;
            current_reg <= fhsm_pkg::EMPTY_RECORD;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // history and clear control
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            histClear_reg <= fhsm_pkg::HIST_CLEAR_RESET;
        end else if (regWrite && regCode == fhsm_pkg::CODE_HIST_CLEAR) begin
            histClear_reg <= regWriteData[0];
        end else begin
            // self-clearing so a second clear can be issued later
            histClear_reg <= 1'b0;
        end
    end

    always_comb begin
        histIndex = 3'h7;
        if (regCode >= fhsm_pkg::CODE_HIST_FIRST && regCode <= fhsm_pkg::CODE_HIST_LAST) begin
            histIndex = 3'(regCode - fhsm_pkg::CODE_HIST_FIRST);
        end
    end

    fhsm_history u_history (
        .core_clk(core_clk),
        .rstn(rstn),
        .shiftIn(faultResetPulse && tripActive),
        .clearAll(histClear_reg),
        .newRecord(current_reg),
        .readIndex(histIndex),
        .readRecord(histRecord)
    );

    ////////////////////////////////////////////////////////////////////////////
    // keypad read path; history data lags the code by one cycle
    function automatic logic [15:0] itemOf(input fhsm_pkg::fhsm_record_type rec,
                                           input logic [1:0] item);
        unique case (item)
            fhsm_pkg::ITEM_FAULT: itemOf = {8'h00, rec.faultCode};
            fhsm_pkg::ITEM_FREQ: itemOf = rec.frequency;
            fhsm_pkg::ITEM_CURRENT: itemOf = rec.current;
            fhsm_pkg::ITEM_PHASE: itemOf = {14'h0000, rec.phase};
        endcase
    endfunction : itemOf

    always_comb begin
        readNext = 16'h0000;
        if (regCode == fhsm_pkg::CODE_INPUT_STATE) begin
            readNext = {11'h000, inputState_reg};
        end else if (regCode == fhsm_pkg::CODE_OUTPUT_STATE) begin
            readNext = {14'h0000, outputState_reg};
        end else if (regCode == fhsm_pkg::CODE_ACTIVE_FAULT) begin
            readNext = itemOf(current_reg, regItem);
        end else if (histIndex != 3'h7) begin
            readNext = itemOf(histRecord, regItem);
        end else if (regCode == fhsm_pkg::CODE_HIST_CLEAR) begin
            readNext = {15'h0000, histClear_reg};
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            regReadData <= 16'h0000;
        end else begin
            regReadData <= readNext;
        end
    end
endmodule : fhsm_monitor

// [src/fhsm_pkg.sv]
// package for the fault history and status monitor: field widths, codes, record layout.
// assumes one core clock, registers reached by parameter code over a simple read/write port.
// Contract
// - live input terminal levels, one bit each, three or five bits wide
// - standard variant reports terminals one to three only, upper bits absent
// - two-bit output state, relay and open collector, zero after reset
// - active fault code shown while a trip is present
// - trip captures fault, frequency, current, phase; read out in that order
// - phase item is accelerating, decelerating or constant speed
// - history holds up to five records, same content as current fault
// - one-bit clear control, reset zero, erases all five entries
// - fault reset moves current record into entry one
// - entry one moves to entry two on the same reset step
// - simultaneous trips share one entry, in sequential order; the code ors their codes and keeps the first snapshot
package fhsm_pkg;
    localparam int NUM_INPUTS = 5;
    localparam int NUM_STD_INPUTS = 3;
    localparam int HIST_DEPTH = 5;
    localparam int FAULT_W = 8;
    localparam int SUB_W = 2;
    localparam logic [7:0] NO_FAULT = 8'h00;
    localparam logic [1:0] OUT_STATE_RESET = 2'h0;
    localparam logic HIST_CLEAR_RESET = 1'b0;

    // parameter codes used as addresses on the keypad access port
    localparam logic [7:0] CODE_INPUT_STATE = 8'h5a;
    localparam logic [7:0] CODE_OUTPUT_STATE = 8'h29;
    localparam logic [7:0] CODE_ACTIVE_FAULT = 8'h00;
    localparam logic [7:0] CODE_HIST_FIRST = 8'h5b;
    localparam logic [7:0] CODE_HIST_LAST = 8'h5f;
    localparam logic [7:0] CODE_HIST_CLEAR = 8'h60;

    // item selector for the sequential read-out of one record
    localparam logic [1:0] ITEM_FAULT = 2'h0;
    localparam logic [1:0] ITEM_FREQ = 2'h1;
    localparam logic [1:0] ITEM_CURRENT = 2'h2;
    localparam logic [1:0] ITEM_PHASE = 2'h3;

    typedef enum logic [1:0] {
        FHSM_PHASE_ACCEL = 2'h0,
        FHSM_PHASE_DECEL = 2'h1,
        FHSM_PHASE_CONST = 2'h3
    } fhsm_phase_type;

    typedef struct packed {
        logic [7:0] faultCode;
        logic [15:0] frequency;
        logic [15:0] current;
        fhsm_phase_type phase;
    } fhsm_record_type;

    localparam fhsm_record_type EMPTY_RECORD = '{
        faultCode: NO_FAULT, frequency: 16'h0000, current: 16'h0000,
        phase: FHSM_PHASE_CONST};
endpackage : fhsm_pkg

// [test/fhsm_keypad.sv]
// keypad reader model: holds one code and item, shows data once settled.
// assumes the monitor answers within three cycles of a code change.
`timescale 1ns/1ns
module fhsm_keypad (
    input wire logic core_clk,
    input wire logic [7:0] wantCode,
    input wire logic [1:0] wantItem,
    input wire logic [15:0] regReadData,
    output logic [7:0] regCode = 8'h00,
    output logic [1:0] regItem = 2'h0,
    output logic [15:0] shown
);
    logic [1:0] age = 2'h0;
    always @(posedge core_clk) begin
        if (regCode != wantCode || regItem != wantItem) age <= 2'h0;
        else if (age != 2'h3) age <= age + 2'h1;
        regCode <= wantCode;
        regItem <= wantItem;
    end
    // a stale display shows garbage, so a slow answer cannot pass by luck
    assign shown = (age == 2'h3) ? regReadData : ~regReadData;
endmodule : fhsm_keypad

// [test/fhsm_monitor_asserts.sv]
// checker for the fault monitor top: trip flag, status widths, record shift.
// assumes it is bound to fhsm_monitor and sees only its ports.
`timescale 1ns/1ns
module fhsm_monitor_asserts #(
    parameter bit ADVANCED_IO = 1'b1
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [4:0] terminalLevel,
    input wire logic tripPulse,
    input wire logic faultResetPulse,
    input wire logic [7:0] regCode,
    input wire logic [1:0] regItem,
    input wire logic regWrite,
    input wire logic [15:0] regReadData,
    input wire logic tripActive
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence readActive;
        regCode == fhsm_pkg::CODE_ACTIVE_FAULT && regItem == 2'h0 && tripActive
            && faultResetPulse && !tripPulse;
    endsequence
    sequence holdFirst;
        (regCode == fhsm_pkg::CODE_HIST_FIRST && regItem == 2'h0 && !faultResetPulse
            && !regWrite)[*3];
    endsequence
    AST_TRIP_SEEN: assert property (tripPulse |=> tripActive) else $error("trip lost");
    AST_TRIP_HELD: assert property (tripActive && !faultResetPulse |=> tripActive)
        else $error("trip dropped");
    AST_TRIP_DONE: assert property (readActive |=> !tripActive) else $error("trip kept");
    AST_OUT_WIDTH: assert property (regCode == fhsm_pkg::CODE_OUTPUT_STATE |=>
        regReadData[15:2] == 14'h0000) else $error("output state too wide");
    // snapshot register plus read register: the level shows two cycles after it is sampled
    AST_IN_LEVEL: assert property (regCode == fhsm_pkg::CODE_INPUT_STATE && ADVANCED_IO
        && $past(rstn) |=> regReadData == {11'h000, $past(terminalLevel, 2)})
        else $error("input levels");
    AST_IN_STD: assert property (regCode == fhsm_pkg::CODE_INPUT_STATE && !ADVANCED_IO
        |=> regReadData[15:3] == 13'h0000) else $error("standard input width");
    AST_IDLE_CODE: assert property (regCode == fhsm_pkg::CODE_ACTIVE_FAULT &&
        regItem == 2'h0 && !tripActive && !tripPulse |=> regReadData == 16'h0000)
        else $error("fault shown while idle");
    // the record read just before the reset must be the one found in entry one after it
    AST_SHIFT_NEWEST: assert property (readActive ##1 holdFirst |=>
        regReadData == $past(regReadData, 3)) else $error("entry one not newest");
endmodule : fhsm_monitor_asserts
bind fhsm_monitor fhsm_monitor_asserts #(.ADVANCED_IO(ADVANCED_IO)) fhsm_monitor_asserts_i (
    .core_clk(core_clk), .rstn(rstn), .terminalLevel(terminalLevel), .tripPulse(tripPulse),
    .faultResetPulse(faultResetPulse), .regCode(regCode), .regItem(regItem),
    .regWrite(regWrite), .regReadData(regReadData), .tripActive(tripActive));

// [test/testbench.sv]
// self-checking bench for the fault monitor with a keypad reader model.
// assumes the checker is bound from its own file.
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %0t got %h want %h", $time, g, e); end end
module testbench;
    logic core_clk, rstn, relayOn, openCollectorOn, tripPulse, faultResetPulse, regWrite;
    logic tripActive;
    logic [4:0] terminalLevel;
    logic [7:0] tripCode, regCode, wantCode;
    logic [1:0] regItem, wantItem;
    logic [15:0] tripFrequency, tripCurrent, regWriteData, regReadData, shown, v, want;
    fhsm_pkg::fhsm_phase_type tripPhase;
    int mismatches = 0;
    int n_tests = 0;
    fhsm_pkg::fhsm_record_type rows[6] = '{'{8'h01, 16'h0bb8, 16'h0032, fhsm_pkg::FHSM_PHASE_ACCEL},
        '{8'h02, 16'h1770, 16'h0040, fhsm_pkg::FHSM_PHASE_DECEL},
        '{8'h08, 16'h0001, 16'hffff, fhsm_pkg::FHSM_PHASE_CONST},
        '{8'h20, 16'hffff, 16'h0001, fhsm_pkg::FHSM_PHASE_ACCEL},
        '{8'h40, 16'h0a5a, 16'h5a5a, fhsm_pkg::FHSM_PHASE_DECEL},
        '{8'h80, 16'h1234, 16'h4321, fhsm_pkg::FHSM_PHASE_CONST}};
    fhsm_monitor fhsm_monitor_i (.core_clk(core_clk), .rstn(rstn), .terminalLevel(terminalLevel),
        .relayOn(relayOn), .openCollectorOn(openCollectorOn), .tripPulse(tripPulse),
        .tripCode(tripCode), .tripFrequency(tripFrequency), .tripCurrent(tripCurrent),
        .tripPhase(tripPhase), .faultResetPulse(faultResetPulse), .regCode(regCode),
        .regItem(regItem), .regWrite(regWrite), .regWriteData(regWriteData),
        .regReadData(regReadData), .tripActive(tripActive));
    fhsm_keypad fhsm_keypad_i (.core_clk(core_clk), .wantCode(wantCode), .wantItem(wantItem),
        .regReadData(regReadData), .regCode(regCode), .regItem(regItem), .shown(shown));
    task automatic tally_and_finish;
        if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    task automatic rd(input logic [7:0] c, input logic [1:0] it);
        @(posedge core_clk);
        wantCode <= c;
        wantItem <= it;
        repeat (5) @(posedge core_clk);
        #1 v = shown;
    endtask : rd
    task automatic pulse(input bit rst, input fhsm_pkg::fhsm_record_type r);
        @(posedge core_clk);
        tripPulse <= !rst;
        faultResetPulse <= rst;
        tripCode <= r.faultCode;
        tripFrequency <= r.frequency;
        tripCurrent <= r.current;
        tripPhase <= r.phase;
        // steer the reader to entry one in the reset cycle itself
        if (rst) wantCode <= fhsm_pkg::CODE_HIST_FIRST;
        @(posedge core_clk);
        tripPulse <= 1'b0;
        faultResetPulse <= 1'b0;
    endtask : pulse
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        mismatches++;
        tally_and_finish();
    end
    initial begin
        {rstn, relayOn, openCollectorOn, tripPulse, faultResetPulse, regWrite} = 6'h00;
        {terminalLevel, tripCode, tripFrequency, tripCurrent, regWriteData} = '0;
        {wantCode, wantItem} = '0;
        tripPhase = fhsm_pkg::FHSM_PHASE_ACCEL;
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        rd(fhsm_pkg::CODE_OUTPUT_STATE, 2'h0);
        `CHK(v, 16'h0000)
        @(posedge core_clk);
        {relayOn, openCollectorOn, terminalLevel} <= 7'h6d;
        rd(fhsm_pkg::CODE_OUTPUT_STATE, 2'h0);
        `CHK(v, 16'h0003)
        rd(fhsm_pkg::CODE_INPUT_STATE, 2'h0);
        `CHK(v, 16'h000d)
        rd(8'h77, 2'h0);
        `CHK(v, 16'h0000)
        for (int k = 0; k < 6; k++) begin
            pulse(1'b0, rows[k]);
            rd(fhsm_pkg::CODE_ACTIVE_FAULT, 2'h0);
            `CHK(v, {8'h00, rows[k].faultCode})
            pulse(1'b1, rows[k]);
            for (int i = 0; i < 4; i++) begin
                rd(fhsm_pkg::CODE_HIST_FIRST, i[1:0]);
                want = (i == 0) ? {8'h00, rows[k].faultCode} : (i == 1) ? rows[k].frequency
                    : (i == 2) ? rows[k].current : {14'h0000, rows[k].phase};
                `CHK(v, want)
            end
            `CHK(v, {14'h0000, rows[k].phase})
        end
        for (int k = 0; k < 5; k++) begin
            rd(fhsm_pkg::CODE_HIST_FIRST + 8'(k), 2'h0);
            `CHK(v, {8'h00, rows[5 - k].faultCode})
        end
        pulse(1'b0, rows[1]);
        pulse(1'b0, rows[2]);
        pulse(1'b1, rows[0]);
        rd(fhsm_pkg::CODE_HIST_FIRST, 2'h0);
        `CHK(v, 16'h000a)
        rd(fhsm_pkg::CODE_HIST_FIRST + 8'h01, 2'h0);
        `CHK(v, {8'h00, rows[5].faultCode})
        rd(fhsm_pkg::CODE_HIST_CLEAR, 2'h0);
        `CHK(v, 16'h0000)
        @(posedge core_clk);
        regWrite <= 1'b1;
        regWriteData <= 16'h0001;
        @(posedge core_clk);
        regWrite <= 1'b0;
        for (int k = 0; k < 6; k++) begin
            rd(k == 5 ? fhsm_pkg::CODE_ACTIVE_FAULT : fhsm_pkg::CODE_HIST_FIRST + 8'(k), 2'h0);
            `CHK(v, 16'h0000)
        end
        // mid-run reset with a stored entry and a live trip: both must read empty after it
        pulse(1'b0, rows[3]);
        pulse(1'b1, rows[3]);
        pulse(1'b0, rows[4]);
        rd(fhsm_pkg::CODE_ACTIVE_FAULT, 2'h0);
        `CHK(tripActive, 1'b1)
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        rd(fhsm_pkg::CODE_HIST_FIRST, 2'h0);
        `CHK(v, 16'h0000)
        `CHK(tripActive, 1'b0)
        rd(fhsm_pkg::CODE_ACTIVE_FAULT, 2'h0);
        `CHK(v, 16'h0000)
        tally_and_finish();
    end
endmodule : testbench
